// ===== core/drpm_core.sv
// Power state and bank idle tracking of the memory device.
// Assumes command pins are synchronous to i_clock and sampled every edge.
//
// How it works
// - all-bank bit high precharges every bank
// - refresh busy for refresh cycle time
// - refresh with clock enable low and all banks idle enters self-refresh
// - exit waits count from first clock-enable-high edge
// - clock enable low with NOP enters power-down
// - idle banks give precharge power-down else active
// - buffers off during power-down, DLL frozen in precharge power-down only
// - clock enable high with NOP exits power-down
`timescale 1ns/1ps
module drpm_core (
  input  wire logic                           i_clock,       // Command clock
  input  wire logic                           i_nrst,        // Async reset, low
  input  wire logic                           i_cke,         // Clock enable pin
  input  wire logic                           i_cs_n,        // Chip select, low
  input  wire logic                           i_ras_n,       // Row strobe, low
  input  wire logic                           i_cas_n,       // Column strobe, low
  input  wire logic                           i_we_n,        // Write enable, low
  input  wire logic [drpm_pkg::ADDR_W-1:0]    i_addr,        // Address pins
  input  wire logic [drpm_pkg::BANK_W-1:0]    i_bank,        // Bank address pins
  output logic      [drpm_pkg::NUM_BANKS-1:0] o_bank_open,   // Open row per bank
  output logic                                o_refresh_busy,// Refresh in progress
  output logic                                o_self_refresh,// In self refresh
  output logic                                o_pre_pd,      // Precharge power-down
  output logic                                o_act_pd,      // Active power-down
  output logic                                o_buffers_off, // Inputs/outputs gated
  output logic                                o_dll_frozen,  // DLL frozen
  output logic                                o_nonread_ok,  // Nonread wait met
  output logic                                o_read_ok      // Read wait met
);
  import drpm_pkg::*;
  // ==========================================================================
  // State record
  typedef struct packed {
    drpm_state_e      state;   // Power state
    logic             cke_q;   // Clock enable at previous edge
    logic [CNT_W-1:0] cnt;     // Wait counter
    logic [CNT_W-1:0] rd_cnt;  // Read wait counter
    logic             nr_ok;   // Nonread wait met
    logic             rd_ok;   // Read wait met
  } drpm_core_s;

  drpm_core_s st;              // Registered state
  drpm_core_s next_st;         // Next state
  logic [2:0] cmd;             // Decoded command
  logic       is_nop;          // NOP or deselect
  logic       cmd_act;         // Activate taken
  logic       cmd_pre;         // Precharge taken
  logic [NUM_BANKS-1:0] open_q;// Registered bank flags

  // Command decode, shared by several checks
  function automatic logic [2:0] decode_cmd(input logic cs_n, input logic ras_n,
                                             input logic cas_n, input logic we_n);
    decode_cmd = cs_n ? CMD_NOP : {ras_n, cas_n, we_n};
  endfunction : decode_cmd

  assign cmd     = decode_cmd(i_cs_n, i_ras_n, i_cas_n, i_we_n);
  assign is_nop  = (cmd == CMD_NOP);
  assign cmd_act = (st.state == DRPM_IDLE_ACTIVE) && st.cke_q && i_cke && (cmd == CMD_ACTIVATE);
  assign cmd_pre = (st.state == DRPM_IDLE_ACTIVE) && st.cke_q && i_cke && (cmd == CMD_PRECHARGE);

  // ==========================================================================
  // Bank open flags
  drpm_bank_mem u_banks (
    .i_clock     (i_clock),
    .i_nrst      (i_nrst),
    .i_activate  (cmd_act),
    .i_precharge (cmd_pre),
    .i_all_banks (i_addr[ALL_BANK_BIT]),
    .i_bank      (i_bank),
    .o_open      (open_q)
  );

  // ==========================================================================
  // Next-state logic
  always_comb begin
    next_st       = st;
    next_st.cke_q = i_cke;
    if (st.rd_cnt != CNT_RESET) begin
      next_st.rd_cnt = st.rd_cnt - 8'h01;
    end
    case (st.state)
      DRPM_IDLE_ACTIVE: begin
        // Entry only from cke high previous edge
        if (st.cke_q && !i_cke && cmd == CMD_REFRESH && open_q == BANKS_RESET) begin
          next_st.state = DRPM_SELF_REF;
        end else if (st.cke_q && !i_cke && is_nop) begin
          next_st.state = (open_q == BANKS_RESET) ? DRPM_PRE_PD : DRPM_ACT_PD;
        end else if (st.cke_q && i_cke && cmd == CMD_REFRESH) begin
          next_st.state = DRPM_REFRESHING;
          next_st.cnt   = RFC_CNT - 8'h01;
        end
      end
      DRPM_REFRESHING: begin
        // Counts the refresh cycle time down
        if (st.cnt == CNT_RESET) begin
          next_st.state = DRPM_IDLE_ACTIVE;
        end else begin
          next_st.cnt = st.cnt - 8'h01;
        end
      end
      DRPM_PRE_PD, DRPM_ACT_PD: begin
        // Synchronous exit on cke high with NOP
        if (i_cke && is_nop) begin
          next_st.state = DRPM_IDLE_ACTIVE;
        end
      end
      DRPM_SELF_REF: begin
        // Exit waits start at first cke high edge
        if (i_cke) begin
          next_st.state  = DRPM_SR_EXIT;
          next_st.nr_ok  = 1'b0;
          next_st.rd_ok  = 1'b0;
          next_st.cnt    = XSNR_CNT - 8'h01;
          next_st.rd_cnt = XSRD_CNT - 8'h01;
        end
      end
      DRPM_SR_EXIT: begin
        // Nonread wait, then normal operation
        if (st.cnt == CNT_RESET) begin
          next_st.state = DRPM_IDLE_ACTIVE;
          next_st.nr_ok = 1'b1;
        end else begin
          next_st.cnt = st.cnt - 8'h01;
        end
      end
      default: begin
        next_st.state = DRPM_IDLE_ACTIVE;
      end
    endcase
    // Read wait ends after the exit-to-read count
    if (!st.rd_ok && st.rd_cnt == CNT_RESET && st.state != DRPM_SELF_REF
        && next_st.state != DRPM_SR_EXIT) begin
      next_st.rd_ok = 1'b1;
    end else if (!st.rd_ok && st.rd_cnt == CNT_RESET && st.state == DRPM_SR_EXIT
                 && next_st.state == DRPM_SR_EXIT) begin
      next_st.rd_ok = 1'b1;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      st.state  <= DRPM_IDLE_ACTIVE;
      st.cke_q  <= 1'b0;
      st.cnt    <= CNT_RESET;
      st.rd_cnt <= CNT_RESET;
      st.nr_ok  <= 1'b1;
      st.rd_ok  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Registered outputs
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bank_open    <= BANKS_RESET;
      o_refresh_busy <= 1'b0;
      o_self_refresh <= 1'b0;
      o_pre_pd       <= 1'b0;
      o_act_pd       <= 1'b0;
      o_buffers_off  <= 1'b0;
      o_dll_frozen   <= 1'b0;
      o_nonread_ok   <= 1'b1;
      o_read_ok      <= 1'b1;
    end else begin
      o_bank_open    <= open_q;
      o_refresh_busy <= (next_st.state == DRPM_REFRESHING);
      o_self_refresh <= (next_st.state == DRPM_SELF_REF);
      o_pre_pd       <= (next_st.state == DRPM_PRE_PD);
      o_act_pd       <= (next_st.state == DRPM_ACT_PD);
      o_buffers_off  <= (next_st.state == DRPM_PRE_PD) || (next_st.state == DRPM_ACT_PD)
                        || (next_st.state == DRPM_SELF_REF);
      o_dll_frozen   <= (next_st.state == DRPM_PRE_PD);
      o_nonread_ok   <= next_st.nr_ok;
      o_read_ok      <= next_st.rd_ok;
    end
  end

  // ==========================================================================
  // Checks
  property p_pd_entry;
    @(posedge i_clock) disable iff (!i_nrst)
      (st.state == DRPM_IDLE_ACTIVE && st.cke_q && !i_cke && is_nop)
      |=> (st.state == DRPM_PRE_PD || st.state == DRPM_ACT_PD);
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered");

  property p_pd_kind;
    @(posedge i_clock) disable iff (!i_nrst)
      (st.state == DRPM_IDLE_ACTIVE && st.cke_q && !i_cke && is_nop && open_q == BANKS_RESET)
      |=> o_pre_pd && o_dll_frozen;
  endproperty
  a_pd_kind: assert property (p_pd_kind) else $error("wrong power-down kind");

  // An open row at entry must give active power-down, DLL left running
  property p_act_pd_kind;
    @(posedge i_clock) disable iff (!i_nrst)
      (st.state == DRPM_IDLE_ACTIVE && st.cke_q && !i_cke && is_nop && open_q != BANKS_RESET)
      |=> o_act_pd && !o_dll_frozen && o_buffers_off;
  endproperty
  a_act_pd_kind: assert property (p_act_pd_kind) else $error("active power-down missed");

  // Buffers stay off, tied to a low-power state, while cke stays low
  property p_buf_off;
    @(posedge i_clock) disable iff (!i_nrst)
      (o_buffers_off && !i_cke) |=> o_buffers_off && (o_pre_pd || o_act_pd || o_self_refresh);
  endproperty
  a_buf_off: assert property (p_buf_off) else $error("buffers on in power-down");

  property p_pd_exit;
    @(posedge i_clock) disable iff (!i_nrst)
      ((st.state == DRPM_PRE_PD || st.state == DRPM_ACT_PD) && i_cke && is_nop)
      |=> st.state == DRPM_IDLE_ACTIVE;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("power-down not exited");

  property p_sr_entry;
    @(posedge i_clock) disable iff (!i_nrst)
      (st.state == DRPM_IDLE_ACTIVE && st.cke_q && !i_cke && cmd == CMD_REFRESH
       && open_q == BANKS_RESET) |=> o_self_refresh;
  endproperty
  a_sr_entry: assert property (p_sr_entry) else $error("self refresh not entered");

  property p_sr_exit_wait;
    @(posedge i_clock) disable iff (!i_nrst)
      (st.state == DRPM_SELF_REF && i_cke) |=> (!st.nr_ok && !st.rd_ok)
      ##(XSNR_CYCLES) st.nr_ok;
  endproperty
  a_sr_exit_wait: assert property (p_sr_exit_wait) else $error("nonread wait wrong");

  property p_rfc;
    @(posedge i_clock) disable iff (!i_nrst)
      (st.state == DRPM_IDLE_ACTIVE && st.cke_q && i_cke && cmd == CMD_REFRESH)
      |=> (st.state == DRPM_REFRESHING)[*3] ##1 st.state == DRPM_IDLE_ACTIVE;
  endproperty
  a_rfc: assert property (p_rfc) else $error("refresh time wrong");

  property p_pre_all;
    @(posedge i_clock) disable iff (!i_nrst)
      (cmd_pre && i_addr[ALL_BANK_BIT]) |=> open_q == BANKS_RESET;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("all-bank precharge missed");

endmodule : drpm_core

// ===== core/drpm_pkg.sv
// Constants for the precharge, refresh and power-down state block.
// Assumes one command clock at 20 MHz, active-low async reset.
package drpm_pkg;
  // ==========================================================================
  // Geometry
  localparam int unsigned NUM_BANKS    = 8;         // Internal banks
  localparam int unsigned BANK_W       = 3;         // Bank address width
  localparam int unsigned ALL_BANK_BIT = 10;        // All-bank select bit index
  localparam int unsigned ADDR_W       = 14;        // Address bus width
  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_PS     = 50000;  // 20 MHz clock period
  localparam int unsigned RFC_TIME_PS       = 127500; // Refresh cycle time (plain default)
  localparam int unsigned RFC_CYCLES        = (RFC_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned XSRD_CYCLES       = 200;    // Exit-to-read wait in clocks
  localparam int unsigned XSNR_TIME_PS      = 137500; // Exit-to-nonread wait (plain default)
  localparam int unsigned XSNR_CYCLES       = (XSNR_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W             = 8;      // Wait counter width
  localparam logic [CNT_W-1:0] RFC_CNT  = CNT_W'(RFC_CYCLES);
  localparam logic [CNT_W-1:0] XSNR_CNT = CNT_W'(XSNR_CYCLES);
  localparam logic [CNT_W-1:0] XSRD_CNT = CNT_W'(XSRD_CYCLES);
  // ==========================================================================
  // Command encodings {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_NOP       = 3'h7;
  localparam logic [2:0] CMD_ACTIVATE  = 3'h3;
  localparam logic [2:0] CMD_READ      = 3'h5;
  localparam logic [2:0] CMD_WRITE     = 3'h4;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_REFRESH   = 3'h1;
  localparam logic [2:0] CMD_MODE      = 3'h0;
  // ==========================================================================
  // Reset values
  localparam logic [NUM_BANKS-1:0] BANKS_RESET = 8'h00;
  localparam logic [CNT_W-1:0]     CNT_RESET   = 8'h00;
  // Power states
  typedef enum logic [2:0] {
    DRPM_IDLE_ACTIVE = 3'b000,  // Normal operation
    DRPM_REFRESHING  = 3'b001,  // Auto refresh in progress
    DRPM_PRE_PD      = 3'b010,  // Precharge power-down
    DRPM_ACT_PD      = 3'b011,  // Active power-down
    DRPM_SELF_REF    = 3'b100,  // Self refresh
    DRPM_SR_EXIT     = 3'b101   // Self refresh exit wait
  } drpm_state_e;
endpackage : drpm_pkg

// ===== core/drpm_bank_mem.sv
// Open-row flags of all banks, with a registered read port.
// Assumes the caller applies precharge, activate and all-bank clear.
`timescale 1ns/1ps
module drpm_bank_mem (
  input  wire logic                           i_clock,     // Command clock
  input  wire logic                           i_nrst,      // Async reset, low
  input  wire logic                           i_activate,  // Open row in bank
  input  wire logic                           i_precharge, // Close row(s)
  input  wire logic                           i_all_banks, // Precharge all banks
  input  wire logic [drpm_pkg::BANK_W-1:0]    i_bank,      // Target bank
  output logic      [drpm_pkg::NUM_BANKS-1:0] o_open       // Registered open flags
);
  import drpm_pkg::*;
  // ==========================================================================
  // Bank update
  // Single register process; loop marks each bank
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_open <= BANKS_RESET;
    end else begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (i_precharge && (i_all_banks || i_bank == BANK_W'(b))) begin
          o_open[b] <= 1'b0;
        end else if (i_activate && i_bank == BANK_W'(b)) begin
          o_open[b] <= 1'b1;
        end
      end
    end
  end
endmodule : drpm_bank_mem

// ===== tb/drpm_ctrl_model.sv
// ============================================================================
// Memory controller model that drives the command pins and clock enable.
// Assumes the bench calls issue and idle; each drive step spans one clock edge.
`timescale 1ns/1ps
module drpm_ctrl_model (
  input  wire logic                        i_clock, // Command clock
  output logic                             o_cke,   // Clock enable pin
  output logic                             o_cs_n,  // Chip select, low
  output logic                             o_ras_n, // Row strobe, low
  output logic                             o_cas_n, // Column strobe, low
  output logic                             o_we_n,  // Write enable, low
  output logic [drpm_pkg::ADDR_W-1:0]      o_addr,  // Address pins
  output logic [drpm_pkg::BANK_W-1:0]      o_bank   // Bank address pins
);
  import drpm_pkg::*;
  int unsigned age; // Edges the present cke level has been registered

  // Idle pins at time zero, deselected; no termination pin, it stays off
  initial begin
    age = 0;
    o_cke = 1'b1;
    o_cs_n = 1'b1;
    {o_ras_n, o_cas_n, o_we_n} = CMD_NOP;
    o_addr = 14'h0000;
    o_bank = 3'h0;
  end

  // One edge, then new pins; a deselect scrambles the unused lines
  task automatic drive(input logic sel, input logic [2:0] c, input logic ke,
                       input logic [ADDR_W-1:0] a, input logic [BANK_W-1:0] b);
    @(posedge i_clock);
    age = (age < 255) ? age + 1 : age;
    #5;
    if (ke !== o_cke) age = 0;
    o_cke = ke;
    o_cs_n = ~sel;
    if (sel) begin
      {o_ras_n, o_cas_n, o_we_n} = c;
      o_addr = a;
      o_bank = b;
    end else begin
      {o_ras_n, o_cas_n, o_we_n} = ~{o_ras_n, o_cas_n, o_we_n};
      o_addr = ~o_addr;
      o_bank = ~o_bank;
    end
  endtask : drive

  // Command with a cke level; a level change waits out the minimum pulse
  // Never a READ or WRITE, so no burst spans a cke change or a read exit
  task automatic issue(input logic [2:0] c, input logic ke,
                       input logic [ADDR_W-1:0] a, input logic [BANK_W-1:0] b);
    if (ke !== o_cke) begin
      while (age < 3) drive(1'b0, CMD_NOP, o_cke, a, b);
    end
    drive(1'b1, c, ke, a, b);
  endtask : issue

  // Deselect for n edges, cke held (waits after exit use only these)
  task automatic idle(input int n);
    repeat (n) drive(1'b0, CMD_NOP, o_cke, 14'h0000, 3'h0);
  endtask : idle
endmodule : drpm_ctrl_model

// ===== tb/testbench.sv
// ============================================================================
// Self-checking bench for the precharge, refresh and power-down block.
// Assumes the controller model drives all command pins and cke.
`timescale 1ns/1ps
module testbench;
  import drpm_pkg::*;
  logic                 i_clock;   // 20 MHz clock
  logic                 i_nrst;    // Async reset, low
  logic                 cke;       // Clock enable
  logic                 cs_n;      // Chip select
  logic                 ras_n;     // Row strobe
  logic                 cas_n;     // Column strobe
  logic                 we_n;      // Write enable
  logic [ADDR_W-1:0]    addr;      // Address
  logic [BANK_W-1:0]    bank;      // Bank address
  logic [NUM_BANKS-1:0] bank_open; // Open rows
  logic                 busy, sref, pre_pd, act_pd, buf_off, dll_frz, nr_ok, rd_ok;
  logic [7:0]           status;    // Packed state outputs
  int                   error_cnt; // Mismatches
  int                   num_checks; // Comparisons
  logic [16:0]          junk;      // Walking pattern for ignored pins
  logic [ADDR_W-1:0]    dc_addr;   // Address the command ignores
  logic [BANK_W-1:0]    dc_bank;   // Bank the command ignores
  assign dc_addr = junk[13:0];
  assign dc_bank = junk[16:14];
  assign status = {nr_ok, rd_ok, sref, pre_pd, act_pd, busy, buf_off, dll_frz};

  // ==========================================================================
  // Clock runs without pause, also in power-down and self refresh
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  // Walking pattern for address and bank pins that a command ignores
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      junk <= 17'h1A5C3;
    end else begin
      junk <= {junk[15:0], junk[16] ^ junk[13]};
    end
  end

  drpm_ctrl_model i_drpm_ctrl_model (.i_clock(i_clock), .o_cke(cke), .o_cs_n(cs_n),
    .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_addr(addr), .o_bank(bank));

  drpm_core i_drpm_core (.i_clock(i_clock), .i_nrst(i_nrst), .i_cke(cke),
    .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_addr(addr),
    .i_bank(bank), .o_bank_open(bank_open), .o_refresh_busy(busy),
    .o_self_refresh(sref), .o_pre_pd(pre_pd), .o_act_pd(act_pd),
    .o_buffers_off(buf_off), .o_dll_frozen(dll_frz), .o_nonread_ok(nr_ok),
    .o_read_ok(rd_ok));

  // ==========================================================================
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Verdict and end of run
  task automatic final_report;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // Watchdog, far beyond the roughly 260 cycles of the tests
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    error_cnt = 0;
    num_checks = 0;
    i_nrst = 1'b0;
    repeat (6) @(posedge i_clock);
    chk(status, 8'hC0);
    chk(bank_open, 8'h00);
    #5 i_nrst = 1'b1;
    i_drpm_ctrl_model.idle(2);
    // Single-bank close versus all-bank close with a stray bank address
    i_drpm_ctrl_model.issue(CMD_ACTIVATE, 1'b1, dc_addr, 3'h2);
    i_drpm_ctrl_model.issue(CMD_ACTIVATE, 1'b1, dc_addr, 3'h5);
    i_drpm_ctrl_model.idle(2);
    chk(bank_open, 8'h24);
    i_drpm_ctrl_model.issue(CMD_PRECHARGE, 1'b1, dc_addr & 14'h3BFF, 3'h2);
    i_drpm_ctrl_model.idle(2);
    chk(bank_open, 8'h20);
    i_drpm_ctrl_model.issue(CMD_ACTIVATE, 1'b1, dc_addr, 3'h1);
    i_drpm_ctrl_model.issue(CMD_PRECHARGE, 1'b1, dc_addr | 14'h0400, dc_bank);
    i_drpm_ctrl_model.idle(2);
    chk(bank_open, 8'h00);
    // Auto refresh with all banks closed, busy for exactly three edges
    i_drpm_ctrl_model.issue(CMD_REFRESH, 1'b1, dc_addr, dc_bank);
    i_drpm_ctrl_model.idle(1);
    chk(status, 8'hC4);
    i_drpm_ctrl_model.idle(2);
    chk(status, 8'hC4);
    i_drpm_ctrl_model.idle(1);
    chk(status, 8'hC0);
    // Precharge power-down, entry and exit
    i_drpm_ctrl_model.issue(CMD_NOP, 1'b0, dc_addr, dc_bank);
    i_drpm_ctrl_model.idle(1);
    chk(status, 8'hD3);
    i_drpm_ctrl_model.idle(3);
    chk(status, 8'hD3);
    i_drpm_ctrl_model.issue(CMD_NOP, 1'b1, dc_addr, dc_bank);
    i_drpm_ctrl_model.idle(1);
    chk(status, 8'hC0);
    // Active power-down with bank 3 open
    i_drpm_ctrl_model.issue(CMD_ACTIVATE, 1'b1, dc_addr, 3'h3);
    i_drpm_ctrl_model.idle(1);
    i_drpm_ctrl_model.issue(CMD_NOP, 1'b0, dc_addr, dc_bank);
    i_drpm_ctrl_model.idle(1);
    chk(status, 8'hCA);
    i_drpm_ctrl_model.issue(CMD_NOP, 1'b1, dc_addr, dc_bank);
    i_drpm_ctrl_model.idle(1);
    chk(status, 8'hC0);
    chk(bank_open, 8'h08);
    // Self refresh asked for with a row open is not taken
    i_drpm_ctrl_model.issue(CMD_REFRESH, 1'b0, dc_addr, dc_bank);
    i_drpm_ctrl_model.idle(1);
    chk(status, 8'hC0);
    i_drpm_ctrl_model.issue(CMD_NOP, 1'b1, dc_addr, dc_bank);
    i_drpm_ctrl_model.idle(1);
    i_drpm_ctrl_model.issue(CMD_PRECHARGE, 1'b1, dc_addr | 14'h0400, dc_bank);
    i_drpm_ctrl_model.idle(2);
    chk(bank_open, 8'h00);
    // Self refresh, exit and both waits counted from the exit edge
    i_drpm_ctrl_model.issue(CMD_REFRESH, 1'b0, dc_addr, dc_bank);
    i_drpm_ctrl_model.idle(1);
    chk(status, 8'hE2);
    i_drpm_ctrl_model.idle(4);
    chk(status, 8'hE2);
    i_drpm_ctrl_model.issue(CMD_NOP, 1'b1, dc_addr, dc_bank);
    i_drpm_ctrl_model.idle(1);
    chk(status, 8'h00);
    i_drpm_ctrl_model.idle(2);
    chk(status, 8'h00);
    i_drpm_ctrl_model.idle(1);
    chk(status, 8'h80);
    i_drpm_ctrl_model.idle(196);
    chk(status, 8'h80);
    i_drpm_ctrl_model.idle(1);
    chk(status, 8'hC0);
    final_report();
  end
endmodule : testbench
